// [hdl/irq_ctrl_consts.svh]
`ifndef IRQ_CTRL_CONSTS_SVH
`define IRQ_CTRL_CONSTS_SVH

// special-function register addresses
`define ADDR_ENABLE_MAIN 8'ha8
`define ADDR_ENABLE_LEVEL_SEC 8'ha9
`define ADDR_LEVEL_MAIN 8'hb8

// reset values
`define RST_ENABLE_MAIN 8'h00
`define RST_ENABLE_LEVEL_SEC 8'ha0
`define RST_LEVEL_MAIN 8'h00

// main enable register fields
`define BIT_GLOBAL_GATE 7
// secondary register fields
`define BIT_SEC_INTERVAL_LEVEL 6
`define BIT_SEC_PSM_LEVEL 5
`define BIT_SEC_SIF_LEVEL 4
`define BIT_SEC_MUST_ZERO 3
`define BIT_SEC_INTERVAL_EN 2
`define BIT_SEC_PSM_EN 1
`define BIT_SEC_SIF_EN 0

// vector addresses
`define VEC_EXT0 16'h0003
`define VEC_TIMER0 16'h000b
`define VEC_EXT1 16'h0013
`define VEC_TIMER1 16'h001b
`define VEC_UART 16'h0023
`define VEC_TIMER2 16'h002b
`define VEC_ADC 16'h0033
`define VEC_SERIAL_IF 16'h003b
`define VEC_SUPPLY_MON 16'h0043
`define VEC_INTERVAL 16'h0053
`define VEC_WATCHDOG 16'h005b

`endif

// [hdl/irq_ctrl_pkg.sv]
package irq_ctrl_pkg;

  // source index, in polling order, highest first
  typedef enum logic [3:0] {
    SRC_SUPPLY_MON,
    SRC_WATCHDOG,
    SRC_EXT0,
    SRC_ADC,
    SRC_TIMER0,
    SRC_EXT1,
    SRC_TIMER1,
    SRC_SERIAL_IF,
    SRC_UART,
    SRC_TIMER2,
    SRC_INTERVAL
  } source_type;

  localparam int NUM_SOURCES = 11;

endpackage : irq_ctrl_pkg

// [hdl/irq_poll_select.sv]
`timescale 1ns/100ps
`default_nettype none

// fixed-order pick of the first active request in a vector; bit 0 wins
module irq_poll_select #(
  parameter int WIDTH = 11
) (
  input wire logic [WIDTH-1:0] request,
  output logic found,
  output logic [3:0] index
);

  logic [WIDTH-1:0] lowerHit;

  // a bit is chosen only when no lower-index bit is active
  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : gChain
      if (g == 0) begin : gFirst
        assign lowerHit[g] = 1'b0;
      end else begin : gRest
        assign lowerHit[g] = lowerHit[g-1] | request[g-1];
      end
    end
  endgenerate

  always_comb begin
    index = 4'h0;
    for (int i = WIDTH - 1; i >= 0; i--) begin
      if (request[i] && !lowerHit[i]) begin
        index = 4'(i);
      end
    end
  end

  assign found = |request;

endmodule : irq_poll_select

`default_nettype wire

// [hdl/irq_vector_rom.sv]
`timescale 1ns/100ps
`default_nettype none
`include "irq_ctrl_consts.svh"

// fixed vector address per source
module irq_vector_rom
  import irq_ctrl_pkg::*;
(
  input wire logic [3:0] index,
  output logic [15:0] vector
);

  always_comb begin
    case (index)
      4'h0: vector = `VEC_SUPPLY_MON;
      4'h1: vector = `VEC_WATCHDOG;
      4'h2: vector = `VEC_EXT0;
      4'h3: vector = `VEC_ADC;
      4'h4: vector = `VEC_TIMER0;
      4'h5: vector = `VEC_EXT1;
      4'h6: vector = `VEC_TIMER1;
      4'h7: vector = `VEC_SERIAL_IF;
      4'h8: vector = `VEC_UART;
      4'h9: vector = `VEC_TIMER2;
      4'ha: vector = `VEC_INTERVAL;
      default: vector = `VEC_EXT0;
    endcase
  end

endmodule : irq_vector_rom

`default_nettype wire

// [hdl/two_level_vectored_irq_controller.sv]
`timescale 1ns/100ps
`default_nettype none
`include "irq_ctrl_consts.svh"

module two_level_vectored_irq_controller
  import irq_ctrl_pkg::*;
#(
  parameter int NUM_SRC = NUM_SOURCES
) (
  input wire logic clk,
  input wire logic sys_rst,
  // special-function register port
  input wire logic [7:0] sfrAddr,
  input wire logic sfrWrite,
  input wire logic [7:0] sfrWriteData,
  input wire logic sfrBitWrite,
  input wire logic [2:0] sfrBitSel,
  input wire logic sfrBitValue,
  output logic [7:0] sfrReadData,
  output logic sfrHit,
  // peripheral flags
  input wire logic supply_monitor_flag,
  input wire logic watchdog_timeout_flag,
  input wire logic watchdog_irq_mode,
  input wire logic watchdogPeriodNonZero,
  input wire logic ext0_request,
  input wire logic ext1_request,
  input wire logic adc_primary_ready,
  input wire logic adc_aux_ready,
  input wire logic timer0_overflow,
  input wire logic timer1_overflow,
  input wire logic timer2_overflow,
  input wire logic timer2_external_flag,
  input wire logic two_wire_flag,
  input wire logic spi_flag,
  input wire logic uart_rx_flag,
  input wire logic uart_tx_flag,
  input wire logic interval_counter_flag,
  // core handshake; coreReady low holds every acceptance off
  // irqReturn is one pulse per executed interrupt return
  input wire logic coreReady,
  input wire logic irqReturn,
  output logic irqTake,
  output logic pushPc,
  output logic [15:0] vectorAddr,
  output logic [3:0] irqSource,
  output logic inServiceHigh,
  output logic inServiceLow,
  output logic watchdogResetReq
);

  // software-visible registers and their next values
  logic [7:0] irq_enable_main_reg;
  logic [7:0] irq_enable_main_next;
  logic [7:0] irq_level_main_reg;
  logic [7:0] irq_level_main_next;
  logic [7:0] irq_enable_level_secondary_reg;
  logic [7:0] irq_enable_level_secondary_next;
  // in-service levels and the registered outputs toward the core
  logic inHigh_reg;
  logic inHigh_next;
  logic inLow_reg;
  logic inLow_next;
  logic take_reg;
  logic [15:0] vector_reg;
  logic [3:0] source_reg;
  logic [7:0] readData_reg;
  logic hit_reg;
  logic wdReset_reg;

  // register selects; only three addresses decode, so any other address
  // reads back as zero with the hit flag low and the core can tell it is unmapped
  wire selMain = (sfrAddr == `ADDR_ENABLE_MAIN);
  wire selLevel = (sfrAddr == `ADDR_LEVEL_MAIN);
  wire selSec = (sfrAddr == `ADDR_ENABLE_LEVEL_SEC);
  wire anySel = selMain | selLevel | selSec;

  // the main enable and level registers are bit-addressable, the secondary
  // one is not; the write logic further down steers bit writes to match
  // field views of the main enable register
  wire global_irq_gate = irq_enable_main_reg[`BIT_GLOBAL_GATE];
  wire adc_irq_enable = irq_enable_main_reg[6];
  wire timer2_irq_enable = irq_enable_main_reg[5];
  wire uart_irq_enable = irq_enable_main_reg[4];
  wire timer1_irq_enable = irq_enable_main_reg[3];
  wire ext1_irq_enable = irq_enable_main_reg[2];
  wire timer0_irq_enable = irq_enable_main_reg[1];
  wire ext0_irq_enable = irq_enable_main_reg[0];

  // level selects from the main level register
  wire adc_level_select = irq_level_main_reg[6];
  wire timer2_level_select = irq_level_main_reg[5];
  wire uart_level_select = irq_level_main_reg[4];
  wire timer1_level_select = irq_level_main_reg[3];
  wire ext1_level_select = irq_level_main_reg[2];
  wire timer0_level_select = irq_level_main_reg[1];
  wire ext0_level_select = irq_level_main_reg[0];

  // secondary register fields
  wire interval_counter_level_select =
    irq_enable_level_secondary_reg[`BIT_SEC_INTERVAL_LEVEL];
  wire supply_monitor_level_select = irq_enable_level_secondary_reg[`BIT_SEC_PSM_LEVEL];
  wire serial_if_level_select = irq_enable_level_secondary_reg[`BIT_SEC_SIF_LEVEL];
  wire interval_counter_irq_enable =
    irq_enable_level_secondary_reg[`BIT_SEC_INTERVAL_EN];
  wire supply_monitor_irq_enable = irq_enable_level_secondary_reg[`BIT_SEC_PSM_EN];
  wire serial_if_irq_enable = irq_enable_level_secondary_reg[`BIT_SEC_SIF_EN];

  // every request below is a level: the peripheral owns its flag and clears
  // it from the service routine, so nothing here latches or clears a request
  // a flag that drops before acceptance is simply forgotten, which matches a
  // core that looks at its sources afresh on every cycle
  // the routine of a paired source reads its peripheral to learn which half fired
  // combined raw requests; paired flags share one vector
  logic [NUM_SRC-1:0] rawReq;
  logic [NUM_SRC-1:0] srcEnable;
  logic [NUM_SRC-1:0] srcHigh;
  logic [NUM_SRC-1:0] gatedReq;
  logic [NUM_SRC-1:0] highReq;
  logic [NUM_SRC-1:0] lowReq;

  // watchdog only counts in interrupt mode with a non-zero period; a zero
  // period never raises a request here, whatever the mode bit says, so a
  // half-configured watchdog cannot flood the core
  wire watchdogIrq = watchdog_timeout_flag & watchdog_irq_mode
    & watchdogPeriodNonZero;

  assign rawReq[SRC_SUPPLY_MON] = supply_monitor_flag;
  assign rawReq[SRC_WATCHDOG] = watchdogIrq;
  assign rawReq[SRC_EXT0] = ext0_request;
  assign rawReq[SRC_ADC] = adc_primary_ready | adc_aux_ready;
  assign rawReq[SRC_TIMER0] = timer0_overflow;
  assign rawReq[SRC_EXT1] = ext1_request;
  assign rawReq[SRC_TIMER1] = timer1_overflow;
  assign rawReq[SRC_SERIAL_IF] = two_wire_flag | spi_flag;
  assign rawReq[SRC_UART] = uart_rx_flag | uart_tx_flag;
  assign rawReq[SRC_TIMER2] = timer2_overflow | timer2_external_flag;
  assign rawReq[SRC_INTERVAL] = interval_counter_flag;

  // per-source enables; the watchdog bypasses the global gate
  // it has no enable bit at all: a timeout in interrupt mode must reach the
  // core even when software has crashed with the gate shut
  assign srcEnable[SRC_SUPPLY_MON] = supply_monitor_irq_enable & global_irq_gate;
  assign srcEnable[SRC_WATCHDOG] = 1'b1;
  assign srcEnable[SRC_EXT0] = ext0_irq_enable & global_irq_gate;
  assign srcEnable[SRC_ADC] = adc_irq_enable & global_irq_gate;
  assign srcEnable[SRC_TIMER0] = timer0_irq_enable & global_irq_gate;
  assign srcEnable[SRC_EXT1] = ext1_irq_enable & global_irq_gate;
  assign srcEnable[SRC_TIMER1] = timer1_irq_enable & global_irq_gate;
  assign srcEnable[SRC_SERIAL_IF] = serial_if_irq_enable & global_irq_gate;
  assign srcEnable[SRC_UART] = uart_irq_enable & global_irq_gate;
  assign srcEnable[SRC_TIMER2] = timer2_irq_enable & global_irq_gate;
  assign srcEnable[SRC_INTERVAL] = interval_counter_irq_enable & global_irq_gate;

  // per-source level; watchdog pinned high
  // pinning it high means a stuck low-level routine can still be interrupted
  // to log why the timeout happened
  assign srcHigh[SRC_SUPPLY_MON] = supply_monitor_level_select;
  assign srcHigh[SRC_WATCHDOG] = 1'b1;
  assign srcHigh[SRC_EXT0] = ext0_level_select;
  assign srcHigh[SRC_ADC] = adc_level_select;
  assign srcHigh[SRC_TIMER0] = timer0_level_select;
  assign srcHigh[SRC_EXT1] = ext1_level_select;
  assign srcHigh[SRC_TIMER1] = timer1_level_select;
  assign srcHigh[SRC_SERIAL_IF] = serial_if_level_select;
  assign srcHigh[SRC_UART] = uart_level_select;
  assign srcHigh[SRC_TIMER2] = timer2_level_select;
  assign srcHigh[SRC_INTERVAL] = interval_counter_level_select;

  // split requests by level, each source picks one of two levels
  // a disabled source is dropped before the split, so it can neither win nor block
  assign gatedReq = rawReq & srcEnable;
  assign highReq = gatedReq & srcHigh;
  assign lowReq = gatedReq & ~srcHigh;

  logic highFound;
  logic lowFound;
  logic [3:0] highIndex;
  logic [3:0] lowIndex;

  // fixed polling within each level; one picker per level so the high pick
  // never waits on the low chain, at the cost of a second chain
  irq_poll_select #(.WIDTH(NUM_SRC)) highPoll (
    .request(highReq),
    .found(highFound),
    .index(highIndex)
  );

  irq_poll_select #(.WIDTH(NUM_SRC)) lowPoll (
    .request(lowReq),
    .found(lowFound),
    .index(lowIndex)
  );

  // acceptance in words:
  //   high request: taken unless a high routine already runs
  //   low request: taken only when nothing runs and no high request waits
  // the cycle after an acceptance is refused, so irqTake is always a single
  // pulse and the new in-service level is settled before the next decision;
  // the price is one cycle of latency on back-to-back requests
  // a high request beats any low one and preempts low service only
  wire acceptHigh = highFound & ~inHigh_reg;
  // low requests wait while anything is in service
  wire acceptLow = lowFound & ~highFound & ~inHigh_reg & ~inLow_reg;
  // the core takes an acceptance only when it is ready and not mid-return
  wire accept = (acceptHigh | acceptLow) & coreReady & ~irqReturn & ~take_reg;
  wire [3:0] pickIndex = acceptHigh ? highIndex : lowIndex;

  logic [15:0] pickVector;

  irq_vector_rom vectorRom (
    .index(pickIndex),
    .vector(pickVector)
  );

  // in-service tracking; return clears the highest active level first
  // with two levels a return always belongs to the higher level in service,
  // since a high routine cannot be interrupted nesting is at most low then
  // high; a return with nothing in service clears nothing
  always_comb begin
    inHigh_next = inHigh_reg;
    inLow_next = inLow_reg;
    if (irqReturn) begin
      if (inHigh_reg) begin
        inHigh_next = 1'b0;
      end else begin
        inLow_next = 1'b0;
      end
    end else if (accept) begin
      if (acceptHigh) begin
        inHigh_next = 1'b1;
      end else begin
        inLow_next = 1'b1;
      end
    end
  end

  // register writes: byte writes to all, bit writes only to bit-addressable ones
  // a byte write wins over a bit write in the same cycle; the core never
  // issues both, but the order keeps the result defined if it does
  // limitation: secondary bit 3 is kept as written and ignored by the logic,
  // so a careless write reads back as one without changing behaviour
  always_comb begin
    irq_enable_main_next = irq_enable_main_reg;
    irq_level_main_next = irq_level_main_reg;
    irq_enable_level_secondary_next = irq_enable_level_secondary_reg;
    if (sfrWrite) begin
      if (selMain) begin
        irq_enable_main_next = sfrWriteData;
      end
      if (selLevel) begin
        irq_level_main_next = {1'b0, sfrWriteData[6:0]};
      end
      if (selSec) begin
        // bit 7 reserved; bit 3 stored as written, software keeps it zero
        irq_enable_level_secondary_next = {1'b1, sfrWriteData[6:0]};
      end
    end else if (sfrBitWrite) begin
      if (selMain) begin
        irq_enable_main_next[sfrBitSel] = sfrBitValue;
      end
      if (selLevel && sfrBitSel != 3'h7) begin
        irq_level_main_next[sfrBitSel] = sfrBitValue;
      end
      // secondary register ignores bit writes: not bit-addressable
    end
  end

  // read mux; read data and hit both lag the address by one cycle, so the
  // core samples them in the cycle after it drives the address
  wire [7:0] readMux = selMain ? irq_enable_main_reg :
                       selLevel ? irq_level_main_reg :
                       selSec ? irq_enable_level_secondary_reg : 8'h00;

  // state and registered outputs
  // one flop stage for every output keeps them glitch-free toward the core;
  // vector and source hold their last values between acceptances so the
  // core may read them late
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      irq_enable_main_reg <= `RST_ENABLE_MAIN;
      irq_level_main_reg <= `RST_LEVEL_MAIN;
      irq_enable_level_secondary_reg <= `RST_ENABLE_LEVEL_SEC;
      inHigh_reg <= 1'b0;
      inLow_reg <= 1'b0;
      take_reg <= 1'b0;
      vector_reg <= 16'h0000;
      source_reg <= 4'h0;
      readData_reg <= 8'h00;
      hit_reg <= 1'b0;
      wdReset_reg <= 1'b0;
    end else begin
      irq_enable_main_reg <= irq_enable_main_next;
      irq_level_main_reg <= irq_level_main_next;
      irq_enable_level_secondary_reg <= irq_enable_level_secondary_next;
      inHigh_reg <= inHigh_next;
      inLow_reg <= inLow_next;
      take_reg <= accept;
      if (accept) begin
        vector_reg <= pickVector;
        source_reg <= pickIndex;
      end
      readData_reg <= readMux;
      hit_reg <= anySel;
      // timeout outside interrupt mode resets the device instead
      wdReset_reg <= watchdog_timeout_flag & ~watchdog_irq_mode;
    end
  end

  // outputs straight from the flops above, no logic after them
  // pushPc and irqTake share one flop so the push never splits from the take
  assign sfrReadData = readData_reg;
  assign sfrHit = hit_reg;
  assign irqTake = take_reg;
  assign pushPc = take_reg;
  assign vectorAddr = vector_reg;
  assign irqSource = source_reg;
  assign inServiceHigh = inHigh_reg;
  assign inServiceLow = inLow_reg;
  assign watchdogResetReq = wdReset_reg;

endmodule : two_level_vectored_irq_controller

`default_nettype wire

// [tb/core_model.sv]
`timescale 1ns/100ps
`default_nettype none
// stand-in for the core's fetch and stack side
module core_model (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic stall,
  input wire logic doReturn,
  input wire logic pushPc,
  input wire logic [15:0] vectorAddr,
  output logic coreReady,
  output logic irqReturn,
  output logic [3:0] depth,
  output logic [15:0] fetchAddr
);
  // ready drops while the core is busy mid-instruction
  assign coreReady = !stall;
  // a return only happens with something on the stack
  assign irqReturn = doReturn && (depth != 4'h0);
  // push on acceptance, pop on return; fetch jumps to the vector
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      depth <= 4'h0;
      fetchAddr <= 16'h0000;
    end else if (pushPc) begin
      depth <= depth + 4'h1;
      fetchAddr <= vectorAddr;
    end else if (irqReturn) begin
      depth <= depth - 4'h1;
    end
  end
endmodule : core_model
`default_nettype wire

// [tb/irq_ctrl_properties.sv]
`timescale 1ns/100ps
`default_nettype none
// port-level checks of acceptance, levels, watchdog and the register read path
module irq_ctrl_checker (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [7:0] sfrAddr,
  input wire logic sfrWrite,
  input wire logic [7:0] sfrWriteData,
  input wire logic sfrBitWrite,
  input wire logic [2:0] sfrBitSel,
  input wire logic sfrBitValue,
  input wire logic [7:0] sfrReadData,
  input wire logic sfrHit,
  input wire logic watchdog_timeout_flag,
  input wire logic watchdog_irq_mode,
  input wire logic watchdogPeriodNonZero,
  input wire logic coreReady,
  input wire logic irqReturn,
  input wire logic irqTake,
  input wire logic pushPc,
  input wire logic [15:0] vectorAddr,
  input wire logic [3:0] irqSource,
  input wire logic inServiceHigh,
  input wire logic inServiceLow,
  input wire logic watchdogResetReq
);
  localparam logic [15:0] VEC_TAB [0:10] = '{16'h0043, 16'h005b, 16'h0003, 16'h0033,
    16'h000b, 16'h0013, 16'h001b, 16'h003b, 16'h0023, 16'h002b, 16'h0053};
  logic gate_reg;
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // shadow of the global gate, since the checker cannot see inside
  always_ff @(posedge clk) begin
    if (sys_rst) gate_reg <= 1'b0;
    else if (sfrWrite && sfrAddr == 8'ha8) gate_reg <= sfrWriteData[7];
    else if (sfrBitWrite && sfrAddr == 8'ha8 && sfrBitSel == 3'h7) gate_reg <= sfrBitValue;
  end
  vector_match_a: assert property (irqTake |-> vectorAddr == VEC_TAB[irqSource])
    else $error("vector does not match source");
  take_ready_a: assert property (irqTake |-> pushPc && $past(coreReady) && !$past(irqReturn))
    else $error("take without push or ready core");
  gate_mask_a: assert property (irqTake && irqSource != 4'h1 |-> $past(gate_reg))
    else $error("maskable take with gate closed");
  wd_cause_a: assert property (irqTake && irqSource == 4'h1 |-> inServiceHigh &&
    $past(watchdog_timeout_flag && watchdog_irq_mode && watchdogPeriodNonZero))
    else $error("bad watchdog take");
  same_level_a: assert property (irqTake |-> !$past(inServiceHigh))
    else $error("take during high service");
  low_preempt_a: assert property (irqTake && $past(inServiceLow) |-> inServiceHigh)
    else $error("low preempted low");
  ret_clear_a: assert property (irqReturn && inServiceHigh |=> !inServiceHigh)
    else $error("return left high level set");
  wd_reset_a: assert property (!$past(sys_rst) |->
    watchdogResetReq == $past(watchdog_timeout_flag && !watchdog_irq_mode))
    else $error("watchdog reset request wrong");
  sec_reserved_a: assert property (sfrHit && $past(sfrAddr) == 8'ha9 |-> sfrReadData[7])
    else $error("secondary bit 7 not one");
endmodule : irq_ctrl_checker
bind two_level_vectored_irq_controller irq_ctrl_checker irq_ctrl_checker_i (
  .clk(clk), .sys_rst(sys_rst), .sfrAddr(sfrAddr), .sfrWrite(sfrWrite),
  .sfrWriteData(sfrWriteData), .sfrBitWrite(sfrBitWrite), .sfrBitSel(sfrBitSel),
  .sfrBitValue(sfrBitValue), .sfrReadData(sfrReadData), .sfrHit(sfrHit),
  .watchdog_timeout_flag(watchdog_timeout_flag), .watchdog_irq_mode(watchdog_irq_mode),
  .watchdogPeriodNonZero(watchdogPeriodNonZero), .coreReady(coreReady),
  .irqReturn(irqReturn), .irqTake(irqTake), .pushPc(pushPc), .vectorAddr(vectorAddr),
  .irqSource(irqSource), .inServiceHigh(inServiceHigh), .inServiceLow(inServiceLow),
  .watchdogResetReq(watchdogResetReq));
`default_nettype wire

// [tb/test_two_level_vectored_irq_controller.sv]
`timescale 1ns/100ps
`default_nettype none
module test_two_level_vectored_irq_controller;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] sfrAddr = 8'h00;
  logic sfrWrite = 1'b0;
  logic [7:0] sfrWriteData = 8'h00;
  logic sfrBitWrite = 1'b0;
  logic [2:0] sfrBitSel = 3'h0;
  logic sfrBitValue = 1'b0;
  logic [15:0] flg = 16'h0000;
  logic wdMode = 1'b0;
  logic wdPer = 1'b0;
  logic stall = 1'b0;
  logic doRet = 1'b0;
  logic [7:0] sfrReadData;
  logic sfrHit, coreReady, irqReturn, irqTake, pushPc, inServiceHigh, inServiceLow;
  logic watchdogResetReq;
  logic [15:0] vectorAddr;
  logic [3:0] irqSource, depth;
  int errors = 0;
  int checks = 0;
  // flag bit that raises each source, in polling order; pairs use their second flag
  logic [3:0] fIdx [0:10] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h5, 4'h6, 4'h7, 4'h9, 4'hb, 4'hd, 4'he};
  logic [15:0] vTab [0:10] = '{16'h0043, 16'h005b, 16'h0003, 16'h0033, 16'h000b, 16'h0013,
    16'h001b, 16'h003b, 16'h0023, 16'h002b, 16'h0053};
  always #2 clk = ~clk;
  two_level_vectored_irq_controller two_level_vectored_irq_controller_i (
    .clk(clk), .sys_rst(sys_rst), .sfrAddr(sfrAddr), .sfrWrite(sfrWrite),
    .sfrWriteData(sfrWriteData), .sfrBitWrite(sfrBitWrite), .sfrBitSel(sfrBitSel),
    .sfrBitValue(sfrBitValue), .sfrReadData(sfrReadData), .sfrHit(sfrHit),
    .supply_monitor_flag(flg[0]), .watchdog_timeout_flag(flg[1]), .watchdog_irq_mode(wdMode),
    .watchdogPeriodNonZero(wdPer), .ext0_request(flg[2]), .ext1_request(flg[6]),
    .adc_primary_ready(flg[3]), .adc_aux_ready(flg[4]), .timer0_overflow(flg[5]),
    .timer1_overflow(flg[7]), .timer2_overflow(flg[12]), .timer2_external_flag(flg[13]),
    .two_wire_flag(flg[8]), .spi_flag(flg[9]), .uart_rx_flag(flg[10]), .uart_tx_flag(flg[11]),
    .interval_counter_flag(flg[14]), .coreReady(coreReady), .irqReturn(irqReturn),
    .irqTake(irqTake), .pushPc(pushPc), .vectorAddr(vectorAddr), .irqSource(irqSource),
    .inServiceHigh(inServiceHigh), .inServiceLow(inServiceLow),
    .watchdogResetReq(watchdogResetReq));
  core_model core_model_i (.clk(clk), .sys_rst(sys_rst), .stall(stall), .doReturn(doRet),
    .pushPc(pushPc), .vectorAddr(vectorAddr), .coreReady(coreReady), .irqReturn(irqReturn),
    .depth(depth), .fetchAddr());
  task automatic wrap_up();
    $display("errors=%0d checks=%0d", errors, checks);
    if (errors == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : wrap_up
  task automatic cmpv(input logic [15:0] g, input logic [15:0] e);
    checks++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %0t got %h want %h", $time, g, e);
    end
  endtask : cmpv
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    sfrAddr = a;
    sfrWriteData = d;
    sfrWrite = 1'b1;
    @(negedge clk);
    sfrWrite = 1'b0;
    // an idle cycle so a following call never re-raises the strobe in this step
    @(negedge clk);
  endtask : wr
  task automatic bw(input logic [7:0] a, input logic [2:0] b, input logic v);
    sfrAddr = a;
    sfrBitSel = b;
    sfrBitValue = v;
    sfrBitWrite = 1'b1;
    @(negedge clk);
    sfrBitWrite = 1'b0;
    @(negedge clk);
  endtask : bw
  // read data and hit are registered, so look one cycle after the address
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic h);
    sfrAddr = a;
    @(negedge clk);
    cmpv({8'h00, sfrReadData}, {8'h00, e});
    cmpv({15'h0000, sfrHit}, {15'h0000, h});
  endtask : rd
  // bounded wait for an acceptance, then check what it carries
  task automatic take(input logic [15:0] v, input logic [3:0] s);
    int n;
    n = 0;
    while (irqTake !== 1'b1 && n < 20) begin
      @(negedge clk);
      n++;
    end
    cmpv({15'h0000, irqTake}, 16'h0001);
    cmpv(vectorAddr, v);
    cmpv({12'h000, irqSource}, {12'h000, s});
  endtask : take
  task automatic none(input int n);
    repeat (n) begin
      @(negedge clk);
      cmpv({15'h0000, irqTake}, 16'h0000);
    end
  endtask : none
  // the core pushes one edge after irqTake, so let that push land before returning
  task automatic ret();
    @(negedge clk);
    doRet = 1'b1;
    @(negedge clk);
    doRet = 1'b0;
    @(negedge clk);
  endtask : ret
  task automatic s_regs();
    rd(8'ha8, 8'h00, 1'b1);
    rd(8'ha9, 8'ha0, 1'b1);
    rd(8'h55, 8'h00, 1'b0);
    wr(8'hb8, 8'hff);
    rd(8'hb8, 8'h7f, 1'b1);
    bw(8'hb8, 3'h0, 1'b0);
    bw(8'hb8, 3'h7, 1'b1);
    rd(8'hb8, 8'h7e, 1'b1);
    wr(8'ha9, 8'h07);
    bw(8'ha9, 3'h6, 1'b1);
    rd(8'ha9, 8'h87, 1'b1);
  endtask : s_regs
  // gate closed holds ext0 off; a busy core holds it off too
  task automatic s_gate();
    wr(8'hb8, 8'h00);
    wr(8'ha8, 8'h01);
    flg[2] = 1'b1;
    none(4);
    stall = 1'b1;
    bw(8'ha8, 3'h7, 1'b1);
    none(3);
    stall = 1'b0;
    take(16'h0003, 4'h2);
    flg[2] = 1'b0;
    ret();
    wr(8'ha8, 8'h80);
    flg[2] = 1'b1;
    none(4);
    flg[2] = 1'b0;
  endtask : s_gate
  // each source but the watchdog, one at a time, or all but the watchdog at once to walk the polling order
  task automatic s_table(input bit all);
    int p;
    wr(8'ha8, 8'hff);
    if (all) flg = 16'h7ffd;
    for (int k = 0; k < 11; k++) begin
      if (k != 1) begin
        if (!all) flg[fIdx[k]] = 1'b1;
        take(vTab[k], k[3:0]);
        p = (k == 0) ? 0 : fIdx[k-1] + 1;
        for (int j = p; j <= fIdx[k]; j++) flg[j] = 1'b0;
        ret();
      end
    end
  endtask : s_table
  task automatic s_levels();
    wr(8'hb8, 8'h06);
    flg[2] = 1'b1;
    flg[5] = 1'b1;
    take(16'h000b, 4'h4);
    flg[5] = 1'b0;
    ret();
    take(16'h0003, 4'h2);
    flg[7] = 1'b1;
    none(6);
    flg[6] = 1'b1;
    take(16'h0013, 4'h5);
    cmpv({14'h0000, inServiceHigh, inServiceLow}, 16'h0003);
    flg[6] = 1'b0;
    flg[2] = 1'b0;
    ret();
    cmpv({14'h0000, inServiceHigh, inServiceLow}, 16'h0001);
    ret();
    take(16'h001b, 4'h6);
    flg[7] = 1'b0;
    ret();
    cmpv({12'h000, depth}, 16'h0000);
  endtask : s_levels
  task automatic s_wdog();
    wr(8'ha8, 8'h00);
    wdMode = 1'b1;
    flg[1] = 1'b1;
    none(4);
    wdPer = 1'b1;
    take(16'h005b, 4'h1);
    cmpv({15'h0000, inServiceHigh}, 16'h0001);
    flg[1] = 1'b0;
    ret();
    wdMode = 1'b0;
    flg[1] = 1'b1;
    none(2);
    cmpv({15'h0000, watchdogResetReq}, 16'h0001);
  endtask : s_wdog
  initial begin
    repeat (4) @(negedge clk);
    sys_rst = 1'b0;
    s_regs();
    s_gate();
    s_table(1'b0);
    s_table(1'b1);
    s_levels();
    s_wdog();
    wrap_up();
  end
  // the tests need well under 1000 cycles
  initial begin
    #20000;
    errors++;
    wrap_up();
  end
endmodule : test_two_level_vectored_irq_controller
`default_nettype wire
